// ### rtl/ipv_unit.sv
// interrupt request sampling, polling and vector call unit
// Functional notes
// - latch all request flags at state 5 phase 2; evaluate them next machine cycle
// - no call while same or higher level routine is in progress
// - call only in the final machine cycle of the running instruction
// - after return or enable/priority write, one more instruction runs first
// - blocked requests are forgotten; each poll uses fresh samples only
// - acknowledge with long call: push PC, not status word, load vector
// - vectors 0003H,000BH,0013H,001BH,0023H,002BH,0043H, then 004BH..006BH step 8
// - serial, timer 2, converter flags stay set; ext 0/1 cleared only if edge
// - ext 2..6 flags always cleared when their routine is called; here a flag write in the call cycle wins over the clear
// - return from interrupt clears current level marker and pops two bytes
// - plain return restores PC but leaves the marker set
// - ext 0/1 trigger bit: 0 follows low level, 1 falling edge
// - edge mode: high sample then low sample sets ext 0/1 flag
// - ext 2/3 polarity bit: 0 falling edge, 1 rising edge
// - ext 4, 5, 6 flags set only on rising edge
// - timer 2 reload flag set on falling trigger pin only when enabled
// - call takes two machine cycles; three cycles minimum to first instruction
// - single-source latency above 3 and below 9 machine cycles
// - higher request before C3 sample point vectors in C5 and C6
// - four levels per pair; preempt only by strictly higher level
// - equal levels resolved by fixed order, left source before right
// - global enable 0 blocks all; else each source has its enable
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ipv_map.svh"

module ipv_unit
#(
   parameter int N_PAIRS = 6        // source pairs
)
(
   input wire logic clock,                   // oscillator clock, 125 MHz
   input wire logic rst_n,                   // asynchronous reset, active low
   input wire logic [3:0] addr,              // register address
   input wire logic [7:0] wr_data,           // register write data
   input wire logic wr_en,                   // write strobe
   input wire logic rd_en,                   // read strobe
   output logic [7:0] rd_data,               // read data, cycle after strobe
   input wire logic [6:0] ext_interrupt_pin, // external pins 0..6
   input wire logic timer2_trigger_pin,      // timer 2 external trigger pin
   input wire logic timer0_overflow_flag,    // peripheral flag
   input wire logic timer1_overflow_flag,    // peripheral flag
   input wire logic timer2_overflow_flag,    // peripheral flag
   input wire logic serial_receive_flag,     // peripheral flag
   input wire logic serial_transmit_flag,    // peripheral flag
   input wire logic converter_done_flag,     // peripheral flag
   input wire logic last_cycle,              // final machine cycle of instruction
   input wire logic return_from_interrupt_op, // running instruction is a return
   output logic long_call_op,                // hardware call in progress
   output logic [15:0] vector_addr,          // target of the hardware call
   output logic [3:0] in_progress            // in-progress marker per level
);
   import ipv_pkg::*;

   localparam int NSRC = 2 * N_PAIRS;

   // ************************************************************
   // elaboration check
   // ************************************************************
   // source table, vectors and register layout are built for six pairs
   if (N_PAIRS != 6)
   begin : g_bad_pairs
      $error("ipv_unit supports exactly six source pairs");
   end

   // ************************************************************
   // reset release and machine cycle divider
   // ************************************************************
   logic rst_meta_reg;
   logic rst_sync_n;
   logic [3:0] mc_cnt_reg;
   logic mc_end;
   logic smp_pt;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // twelve oscillator periods per machine cycle
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         mc_cnt_reg <= 4'h0;
      else if (mc_cnt_reg == `IPV_MC_LAST)
         mc_cnt_reg <= 4'h0;
      else
         mc_cnt_reg <= mc_cnt_reg + 4'h1;
   end

   assign mc_end = (mc_cnt_reg == `IPV_MC_LAST);
   assign smp_pt = (mc_cnt_reg == `IPV_SMP_PT_CNT);

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] int_enable_reg_a;
   logic [7:0] int_enable_reg_b;
   logic [5:0] priority_reg_low;
   logic [5:0] priority_reg_high;
   logic trig0_reg;
   logic trig1_reg;
   logic ext2_polarity_bit;
   logic ext3_polarity_bit;
   logic ctrl_wr_seen_reg;
   logic wr_ctrl;

   // enable and priority registers written by software
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         int_enable_reg_a <= `IPV_RST_BYTE;
         int_enable_reg_b <= `IPV_RST_BYTE;
         priority_reg_low <= 6'h00;
         priority_reg_high <= 6'h00;
      end
      else if (wr_en)
      begin
         if (addr == `IPV_OFS_IEN_A)
            int_enable_reg_a <= wr_data;
         if (addr == `IPV_OFS_IEN_B)
            int_enable_reg_b <= wr_data;
         if (addr == `IPV_OFS_PRIO_LOW)
            priority_reg_low <= wr_data[5:0];
         if (addr == `IPV_OFS_PRIO_HIGH)
            priority_reg_high <= wr_data[5:0];
      end
   end

   // trigger type and polarity selections
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         trig0_reg <= 1'b0;
         trig1_reg <= 1'b0;
         ext2_polarity_bit <= 1'b0;
         ext3_polarity_bit <= 1'b0;
      end
      else if (wr_en)
      begin
         if (addr == `IPV_OFS_TIMER_CTRL)
         begin
            trig0_reg <= wr_data[`IPV_BIT_TRIG0];
            trig1_reg <= wr_data[`IPV_BIT_TRIG1];
         end
         if (addr == `IPV_OFS_TIMER2_CTRL)
         begin
            ext2_polarity_bit <= wr_data[`IPV_BIT_POL2];
            ext3_polarity_bit <= wr_data[`IPV_BIT_POL3];
         end
      end
   end

   // ************************************************************
   // pin sampling
   // ************************************************************
   logic [7:0] pin_vec;
   logic [7:0] rise_sel;
   logic [7:0] pin_level;
   logic [7:0] pin_hit;

   assign pin_vec = {timer2_trigger_pin, ext_interrupt_pin};
   // ext 0/1 and reload trigger fall, ext 2/3 selectable, ext 4..6 rise
   assign rise_sel = {1'b0, 3'b111, ext3_polarity_bit, ext2_polarity_bit, 2'b00};

   for (genvar g = 0; g < 8; g++)
   begin : g_pin
      ipv_pin_sampler u_smp
      (
         .clock(clock),
         .rst_n(rst_sync_n),
         .pin(pin_vec[g]),
         .sample_en(smp_pt),
         .rising(rise_sel[g]),
         .level(pin_level[g]),
         .edge_hit(pin_hit[g])
      );
   end

   // ************************************************************
   // polling and priority
   // ************************************************************
   ipv_call_state_type call_state_reg;
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] en;
   logic [NSRC-1:0] sample_reg;
   logic [NSRC-1:0] poll_reg;
   logic found;
   ipv_src_idx_type win_idx;
   ipv_level_type win_lvl;
   ipv_level_type lvl;
   ipv_level_type top_lvl;
   logic eff_last;
   logic blk;
   logic ack;
   logic ext0_request_flag_reg;
   logic ext1_request_flag_reg;
   logic [4:0] ext_flag_reg;
   logic timer2_ext_reload_flag_reg;

   // source order: pair by pair, left source then right source
   assign req = {ext_flag_reg[4], timer2_overflow_flag | timer2_ext_reload_flag_reg,
                 ext_flag_reg[3], serial_receive_flag | serial_transmit_flag,
                 ext_flag_reg[2], timer1_overflow_flag,
                 ext_flag_reg[1], ext1_request_flag_reg,
                 ext_flag_reg[0], timer0_overflow_flag,
                 converter_done_flag, ext0_request_flag_reg};

   // each source gated by its own enable bit
   always_comb
   begin
      en = '0;
      for (int i = 0; i < N_PAIRS; i++)
      begin
         en[2*i] = int_enable_reg_a[i];
         en[2*i+1] = int_enable_reg_b[i];
      end
   end

   // sample at the sample point, hand over to the next cycle's poll
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sample_reg <= '0;
         poll_reg <= '0;
      end
      else
      begin
         if (smp_pt)
            sample_reg <= req;
         if (mc_end)
            poll_reg <= sample_reg;
      end
   end

   // highest level wins; strict compare keeps the earlier source on a tie
   always_comb
   begin
      lvl = 2'b00;
      found = 1'b0;
      win_idx = 4'h0;
      win_lvl = 2'b00;
      for (int i = 0; i < NSRC; i++)
      begin
         lvl = {priority_reg_high[i/2], priority_reg_low[i/2]};
         if (poll_reg[i] && en[i] && (!found || lvl > win_lvl))
         begin
            found = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl;
         end
      end
   end

   // highest level whose routine is still active
   always_comb
   begin
      top_lvl = 2'b00;
      for (int l = 0; l < 4; l++)
         if (in_progress[l])
            top_lvl = 2'(l);
   end

   // second call cycle ends like an instruction, so a higher request may chain
   always_comb
   begin
      case (call_state_reg)
         IPV_IDLE: eff_last = last_cycle;
         IPV_CALL1: eff_last = 1'b0;
         IPV_CALL2: eff_last = 1'b1;
         default: eff_last = 1'b0;
      endcase
   end

   // a control write on the polling edge itself blocks too
   assign blk = (call_state_reg == IPV_IDLE)
                && (return_from_interrupt_op || ctrl_wr_seen_reg || wr_ctrl);
   assign ack = mc_end && found && int_enable_reg_a[`IPV_BIT_GLOBAL_EN] && eff_last && !blk
                && (in_progress == 4'h0 || win_lvl > top_lvl);
   assign wr_ctrl = wr_en && (addr <= `IPV_OFS_PRIO_HIGH);

   // enable/priority write marks the instruction; cleared when it ends
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         ctrl_wr_seen_reg <= 1'b0;
      else if (wr_ctrl)
         ctrl_wr_seen_reg <= 1'b1;
      else if (mc_end && eff_last)
         ctrl_wr_seen_reg <= 1'b0;
   end

   // ************************************************************
   // request flags
   // ************************************************************
   logic wr_tctl;
   logic wr_xflag;

   assign wr_tctl = wr_en && (addr == `IPV_OFS_TIMER_CTRL);
   assign wr_xflag = wr_en && (addr == `IPV_OFS_EXT_FLAGS);

   // ext 0/1: follow the low level, or latch the falling edge; set beats clear
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ext0_request_flag_reg <= 1'b0;
         ext1_request_flag_reg <= 1'b0;
      end
      else
      begin
         if (!trig0_reg)
            ext0_request_flag_reg <= !pin_level[0];
         else if (pin_hit[0])
            ext0_request_flag_reg <= 1'b1;
         else if (wr_tctl)
            ext0_request_flag_reg <= wr_data[`IPV_BIT_FLAG0];
         else if (ack && win_idx == 4'h0)
            ext0_request_flag_reg <= 1'b0;
         if (!trig1_reg)
            ext1_request_flag_reg <= !pin_level[1];
         else if (pin_hit[1])
            ext1_request_flag_reg <= 1'b1;
         else if (wr_tctl)
            ext1_request_flag_reg <= wr_data[`IPV_BIT_FLAG1];
         else if (ack && win_idx == 4'h4)
            ext1_request_flag_reg <= 1'b0;
      end
   end

   // ext 2..6 flags: edge sets, call clears, edge or flag write beats the call; reload flag only by software
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ext_flag_reg <= 5'h00;
         timer2_ext_reload_flag_reg <= 1'b0;
      end
      else
      begin
         for (int k = 0; k < 5; k++)
         begin
            if (pin_hit[k+2])
               ext_flag_reg[k] <= 1'b1;
            else if (wr_xflag)
               ext_flag_reg[k] <= wr_data[k];
            else if (ack && win_idx == 4'(2*k+3))
               ext_flag_reg[k] <= 1'b0;
         end
         if (pin_hit[7] && int_enable_reg_b[`IPV_BIT_T2_EXT_EN])
            timer2_ext_reload_flag_reg <= 1'b1;
         else if (wr_xflag)
            timer2_ext_reload_flag_reg <= wr_data[`IPV_BIT_RELOAD];
      end
   end

   // ************************************************************
   // call sequencer, markers and outputs
   // ************************************************************
   // two machine cycles per hardware call; vector held through both
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         call_state_reg <= IPV_IDLE;
         long_call_op <= 1'b0;
         vector_addr <= 16'h0000;
      end
      else if (mc_end)
      begin
         case (call_state_reg)
            IPV_CALL1:
            begin
               call_state_reg <= IPV_CALL2;
               long_call_op <= 1'b1;
            end
            IPV_IDLE, IPV_CALL2:
            begin
               call_state_reg <= ack ? IPV_CALL1 : IPV_IDLE;
               long_call_op <= ack;
            end
            default:
            begin
               call_state_reg <= IPV_IDLE;
               long_call_op <= 1'b0;
            end
         endcase
         if (ack)
            vector_addr <= (win_idx[0] ? `IPV_VEC_RIGHT_BASE : `IPV_VEC_LEFT_BASE)
                           + {10'h000, win_idx[3:1], 3'b000};
      end
   end

   // marker set on call; only the interrupt return clears, a plain return does not
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         in_progress <= 4'h0;
      else if (ack)
         in_progress[win_lvl] <= 1'b1;
      else if (mc_end && last_cycle && return_from_interrupt_op && call_state_reg == IPV_IDLE)
         in_progress[top_lvl] <= 1'b0;
   end

   // read port; unmapped addresses read zero
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         rd_data <= `IPV_RST_BYTE;
      else if (rd_en)
      begin
         case (addr)
            `IPV_OFS_IEN_A: rd_data <= int_enable_reg_a;
            `IPV_OFS_IEN_B: rd_data <= int_enable_reg_b;
            `IPV_OFS_PRIO_LOW: rd_data <= {2'b00, priority_reg_low};
            `IPV_OFS_PRIO_HIGH: rd_data <= {2'b00, priority_reg_high};
            `IPV_OFS_TIMER_CTRL: rd_data <= {4'h0, ext1_request_flag_reg, trig1_reg,
                                             ext0_request_flag_reg, trig0_reg};
            `IPV_OFS_TIMER2_CTRL: rd_data <= {1'b0, ext3_polarity_bit, ext2_polarity_bit, 5'h00};
            `IPV_OFS_EXT_FLAGS: rd_data <= {timer2_ext_reload_flag_reg, 2'b00, ext_flag_reg};
            `IPV_OFS_STATUS: rd_data <= {3'b000, long_call_op, in_progress};
            default: rd_data <= `IPV_RST_BYTE;
         endcase
      end
      else
         rd_data <= `IPV_RST_BYTE;
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence seq_call_pair;
      (call_state_reg == IPV_CALL1 && long_call_op) ##12 (call_state_reg == IPV_CALL2);
   endsequence

   chk_call_two_cycles: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ack |=> seq_call_pair)
      else $error("hardware call did not span two machine cycles");

   chk_global_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ack |-> int_enable_reg_a[`IPV_BIT_GLOBAL_EN] && en[win_idx])
      else $error("call taken with source or global enable off");

   chk_final_cycle: assert property (@(posedge clock) disable iff (!rst_sync_n)
      (ack && call_state_reg == IPV_IDLE) |-> last_cycle)
      else $error("call taken before instruction end");

   chk_return_from_interrupt_op_block: assert property (@(posedge clock) disable iff (!rst_sync_n)
      (ack && call_state_reg == IPV_IDLE) |-> !return_from_interrupt_op && !ctrl_wr_seen_reg)
      else $error("call taken right after return or control write");

   chk_level_above: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ack |-> (in_progress == 4'h0) || (win_lvl > top_lvl))
      else $error("call at or below active level");

   chk_vector_map: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ack |=> vector_addr[2:0] == 3'h3 && vector_addr[15:7] == 9'h000
      && vector_addr[6] == $past(win_idx[0]) && vector_addr[5:3] == $past(win_idx[3:1]))
      else $error("wrong vector address");

   chk_ext_clear: assert property (@(posedge clock) disable iff (!rst_sync_n)
      (ack && win_idx == 4'h3 && !pin_hit[2] && !wr_xflag) |=> !ext_flag_reg[0])
      else $error("ext 2 flag not cleared on call");

   chk_return_from_interrupt_op_marker: assert property (@(posedge clock) disable iff (!rst_sync_n)
      (mc_end && last_cycle && return_from_interrupt_op && call_state_reg == IPV_IDLE
      && in_progress != 4'h0) |=> $countones(in_progress) == $countones($past(in_progress)) - 1)
      else $error("return did not clear one marker");

   chk_sample_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !mc_end |=> $stable(poll_reg))
      else $error("poll samples changed inside a machine cycle");

   chk_reload_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ($rose(timer2_ext_reload_flag_reg) && !$past(wr_xflag)) |->
      $past(int_enable_reg_b[`IPV_BIT_T2_EXT_EN]) && $past(pin_hit[7]))
      else $error("reload flag set without enable or falling edge");

endmodule

`default_nettype wire

// ### shared/ipv_map.svh
// offsets, field positions, reset values and timing counts of the interrupt poll unit
`ifndef IPV_MAP_SVH
`define IPV_MAP_SVH

// ***********************************************************************
// timing
// ***********************************************************************
// machine cycle length in oscillator periods; the clock is the oscillator
`define IPV_MC_OSC_PERIODS 12
`define IPV_MC_CYCLES (`IPV_MC_OSC_PERIODS * 1)
// divider count of the last oscillator period in a machine cycle
`define IPV_MC_LAST 4'(`IPV_MC_CYCLES - 1)
// divider count of state 5 phase 2: (5 - 1) * 2 + 2 - 1
`define IPV_SMP_PT_CNT 4'h9

// ***********************************************************************
// register offsets
// ***********************************************************************
`define IPV_OFS_IEN_A 4'h0
`define IPV_OFS_IEN_B 4'h1
`define IPV_OFS_PRIO_LOW 4'h2
`define IPV_OFS_PRIO_HIGH 4'h3
`define IPV_OFS_TIMER_CTRL 4'h4
`define IPV_OFS_TIMER2_CTRL 4'h5
`define IPV_OFS_EXT_FLAGS 4'h6
`define IPV_OFS_STATUS 4'h7

// ***********************************************************************
// field positions
// ***********************************************************************
`define IPV_BIT_GLOBAL_EN 7
`define IPV_BIT_T2_EXT_EN 7
`define IPV_BIT_TRIG0 0
`define IPV_BIT_FLAG0 1
`define IPV_BIT_TRIG1 2
`define IPV_BIT_FLAG1 3
`define IPV_BIT_POL2 5
`define IPV_BIT_POL3 6
`define IPV_BIT_RELOAD 7

// ***********************************************************************
// reset values and vectors
// ***********************************************************************
`define IPV_RST_BYTE 8'h00
`define IPV_VEC_LEFT_BASE 16'h0003
`define IPV_VEC_RIGHT_BASE 16'h0043

`endif

// ### shared/ipv_pkg.sv
// types shared by the interrupt poll unit
package ipv_pkg;

   // sequencer of the hardware long call, one-hot
   typedef enum logic [2:0]
   {
      IPV_IDLE = 3'b001,
      IPV_CALL1 = 3'b010,
      IPV_CALL2 = 3'b100
   } ipv_call_state_type;

   typedef logic [1:0] ipv_level_type;
   typedef logic [3:0] ipv_src_idx_type;

endpackage

// ### rtl/ipv_pin_sampler.sv
// synchroniser and once-per-machine-cycle edge sampler for one interrupt pin
`timescale 1ns/10ps
`default_nettype none

module ipv_pin_sampler
(
   input wire logic clock,          // oscillator clock
   input wire logic rst_n,          // synchronised reset, active low
   input wire logic pin,            // raw pin level
   input wire logic sample_en,      // sample point pulse
   input wire logic rising,         // 1 rising edge, 0 falling edge
   output logic level,              // last sampled level
   output logic edge_hit            // one-clock pulse on chosen transition
);

   logic sync1_reg;
   logic sync2_reg;
   logic smp_reg;
   logic hit_reg;

   // two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
      end
   end

   // one sample per machine cycle; idle high avoids a false edge after reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smp_reg <= 1'b1;
         hit_reg <= 1'b0;
      end
      else
      begin
         hit_reg <= 1'b0;
         if (sample_en)
         begin
            smp_reg <= sync2_reg;
            hit_reg <= rising ? (!smp_reg && sync2_reg) : (smp_reg && !sync2_reg);
         end
      end
   end

   assign level = smp_reg;
   assign edge_hit = hit_reg;

endmodule

`default_nettype wire

// ### tb/ipv_seq_model.sv
// behavioural instruction sequencer facing the interrupt poll unit
`timescale 1ns/10ps
`default_nettype none

module ipv_seq_model
(
   input wire logic clock,                // oscillator clock
   input wire logic exit_req,             // pulse: run one return instruction
   output logic last_cycle,               // final cycle of instruction
   output logic return_from_interrupt_op  // return instruction running
);
   int exit_cnt = 0;
   int win_cnt = 0;
   int mc_no = 0;
   // every third twelve-clock window is the first half of a two-cycle instruction
   always @(posedge clock)
   begin
      win_cnt <= (win_cnt == 11) ? 0 : win_cnt + 1;
      if (win_cnt == 11)
         mc_no <= (mc_no == 2) ? 0 : mc_no + 1;
      if (exit_req)
         exit_cnt <= 12;
      else if (exit_cnt > 0)
         exit_cnt <= exit_cnt - 1;
   end
   // a return spans exactly one cycle end and is its own last cycle
   assign last_cycle = (mc_no != 1) || (exit_cnt > 0);
   assign return_from_interrupt_op = (exit_cnt > 0);
endmodule

`default_nettype wire

// ### tb/ipv_unit_tb.sv
// self-checking bench of the interrupt poll unit
`timescale 1ns/10ps
`default_nettype none

module ipv_unit_tb;
   logic clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, exit_req = 1'b0;
   logic [3:0] addr = 4'h0, in_progress;
   logic [7:0] wr_data = 8'h00, rd_data, rv;
   logic [7:0] pins = 8'h8F;
   logic [5:0] pf = 6'h00;
   logic [1:0] lvl;
   logic last_cycle, exit_op, long_call_op;
   logic [15:0] vector_addr;
   int miscompares = 0, checks_done = 0, seed = 46, i, n;
   always #4 clock = ~clock;
   ipv_unit i_ipv_unit (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_interrupt_pin(pins[6:0]),
      .timer2_trigger_pin(pins[7]), .timer0_overflow_flag(pf[0]), .timer1_overflow_flag(pf[1]),
      .timer2_overflow_flag(pf[2]), .serial_receive_flag(pf[3]), .serial_transmit_flag(pf[4]),
      .converter_done_flag(pf[5]), .last_cycle(last_cycle), .return_from_interrupt_op(exit_op),
      .long_call_op(long_call_op), .vector_addr(vector_addr), .in_progress(in_progress));
   ipv_seq_model i_ipv_seq_model (.clock(clock), .exit_req(exit_req), .last_cycle(last_cycle),
      .return_from_interrupt_op(exit_op));
   task automatic close_out;
   begin
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
   begin
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   // vector of a source in poll order: left ones from 0003h, right ones from 0043h
   function automatic logic [15:0] exp_vec(input int idx);
      return ((idx % 2) ? 16'h0043 : 16'h0003) + 16'(8 * (idx / 2));
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
   begin
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   end
   endtask
   task automatic rd(input logic [3:0] a);
   begin
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 rv = rd_data;
   end
   endtask
   // pin level held for a random span of at least two machine cycles
   task automatic hold(input int k, input logic v);
   begin
      @(posedge clock);
      pins[k] <= v;
      repeat (24 + $unsigned($random(seed)) % 13) @(posedge clock);
   end
   endtask
   // waits for the call, checks it, then runs the return
   task automatic serve(input logic [15:0] vec, input logic [3:0] mark);
   begin
      i = 0;
      while (long_call_op !== 1'b1 && i < 300)
      begin
         @(posedge clock);
         #1 i++;
      end
      // the routine drops level requests and clears peripheral flags early
      pins[0] <= 1'b1;
      pf <= 6'h00;
      chk("vector", vec, vector_addr);
      chk("marker", {12'h000, mark}, {12'h000, in_progress});
      repeat (25) @(posedge clock);
      chk("call end", 16'h0000, {15'h0000, long_call_op});
      exit_req <= 1'b1;
      @(posedge clock);
      exit_req <= 1'b0;
      repeat (30) @(posedge clock);
      chk("marker clear", 16'h0000, {12'h000, in_progress});
   end
   endtask
   initial
   begin
      #400000;
      miscompares++;
      close_out;
   end
   initial
   begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h81);
      hold(0, 1'b0);
      serve(exp_vec(0), 4'h1);
      rd(4'h4);
      chk("ext0 flag", 16'h0000, {15'h0000, rv[1]});
      // right-hand pins, random level each
      for (n = 4; n < 7; n++)
      begin
         lvl = 2'($random(seed));
         wr(4'h2, {8{lvl[0]}} & 8'h3F);
         wr(4'h3, {8{lvl[1]}} & 8'h3F);
         wr(4'h1, 8'h01 << (n - 1));
         hold(n, 1'b1);
         serve(exp_vec(2 * n - 1), 4'h1 << lvl);
         rd(4'h6);
         chk("ext flag", 16'h0000, {15'h0000, rv[n - 2]});
         hold(n, 1'b0);
      end
      // global enable off: flag sets but no call follows
      wr(4'h0, 8'h00);
      hold(6, 1'b1);
      repeat (60) @(posedge clock);
      chk("blocked", 16'h0000, {15'h0000, long_call_op});
      rd(4'h6);
      chk("ext6 flag", 16'h0001, {15'h0000, rv[4]});
      rd(4'hA);
      chk("unmapped", 16'h0000, {8'h00, rv});
      // level-triggered ext0, held until the call
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h83);
      hold(0, 1'b0);
      serve(exp_vec(0), 4'h1);
      // converter and timer 0 together: equal level, then timer 0 raised
      for (n = 0; n < 2; n++)
      begin
         wr(4'h2, 8'(2 * n));
         pf <= 6'h21;
         serve(exp_vec(n ? 2 : 1), n ? 4'h2 : 4'h1);
      end
      // reload flag gated by its enable; ext2 on rising edge
      wr(4'h1, 8'h00);
      wr(4'h5, 8'h20);
      hold(7, 1'b0);
      hold(2, 1'b0);
      rd(4'h6);
      chk("flags off", 16'h0000, {14'h0000, rv[7], rv[0]});
      wr(4'h1, 8'h80);
      hold(7, 1'b1);
      hold(7, 1'b0);
      hold(2, 1'b1);
      rd(4'h6);
      chk("flags on", 16'h0003, {14'h0000, rv[7], rv[0]});
      close_out;
   end
endmodule

`default_nettype wire
